/* dv/qmsa_bus_sink.sv */
`timescale 1ns/10ps
module qmsa_bus_sink (
   input  wire logic          clk_i,
   input  wire logic [15:0]   result_i,
   input  wire logic          oe_i,
   output logic      [15:0]   bus_level_o
);
   logic [15:0] last;
   always_ff @(posedge clk_i) if (oe_i) last <= result_i;
   // floating bus shows no stale value
   assign bus_level_o = oe_i ? result_i : ~last;
endmodule : qmsa_bus_sink

/* dv/qmsa_top_props.sv */
`timescale 1ns/10ps
module qmsa_top_props (
   input wire logic          clk_i,
   input wire logic          arst_n_i,
   input wire logic [39:0]   lane_data_in_i,
   input wire logic [43:0]   lane_coef_in_i,
   input wire logic [3:0]    lane_input_enable_n_i,
   input wire logic          enable_target_select_i,
   input wire logic          output_reg_clock_enable_n_i,
   input wire logic          number_format_select_i,
   input wire logic          accumulate_control_i,
   input wire logic          output_drive_enable_n_i,
   input wire logic [15:0]   result_bus_o,
   input wire logic          result_bus_oe_o,
   input wire logic          psel_i,
   input wire logic          penable_i,
   input wire logic          pwrite_i,
   input wire logic [11:0]   paddr_i,
   input wire logic [31:0]   pwdata_i
);
   logic hold_q;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) hold_q <= 1'b0;
      else if (psel_i && penable_i && pwrite_i && paddr_i == 12'h000) hold_q <= pwdata_i[0];
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   sequence s_smp(e, es, d, c, fs, ac);
      lane_input_enable_n_i == e && (e == 4'h0 || enable_target_select_i == es) &&
      lane_data_in_i == d && lane_coef_in_i == c &&
      number_format_select_i == fs && accumulate_control_i == ac;
   endsequence
   sequence s_one(ac);
      s_smp(4'h0, 1'b0, 40'h00_0000_0001, 44'h000_0000_0001, 1'b1, ac);
   endsequence
   sequence s_load;
      !output_reg_clock_enable_n_i && !hold_q;
   endsequence
   property p_oe; result_bus_oe_o |-> !output_drive_enable_n_i; endproperty
   a_oe: assert property (p_oe) else $error("bus driven while drive enable high");
   property p_hold; output_reg_clock_enable_n_i |=> $stable(result_bus_o); endproperty
   a_hold: assert property (p_hold) else $error("result changed while held");
   property p_zero;
      s_smp(4'h0, 1'b0, 40'h0, 44'h0, 1'b1, 1'b0) ##4 s_load |=> result_bus_o == 16'h0000;
   endproperty
   a_zero: assert property (p_zero) else $error("zero sample not zero");
   property p_lat; s_one(1'b0) ##4 s_load |=> result_bus_o == 16'h0001; endproperty
   a_lat: assert property (p_lat) else $error("latency or integer output wrong");
   property p_accum;
      s_one(1'b0) ##1 s_one(1'b1) ##4 s_load |=> result_bus_o == 16'h0002;
   endproperty
   a_accum: assert property (p_accum) else $error("accumulation wrong");
   property p_round;
      s_smp(4'h0, 1'b0, 40'h00_0000_0001, 44'h000_0000_0100, 1'b0, 1'b0) ##4 s_load
      |=> result_bus_o == 16'h0001;
   endproperty
   a_round: assert property (p_round) else $error("half lsb rounding missing");
   property p_keep_data;
      s_one(1'b0) ##1 s_smp(4'h1, 1'b1, 40'h0, 44'h000_0000_0001, 1'b1, 1'b0) ##4 s_load
      |=> result_bus_o == 16'h0001;
   endproperty
   a_keep_data: assert property (p_keep_data) else $error("data reg not held");
   property p_keep_coef;
      s_one(1'b0) ##1 s_smp(4'h1, 1'b0, 40'h00_0000_0001, 44'h0, 1'b1, 1'b0) ##4 s_load
      |=> result_bus_o == 16'h0001;
   endproperty
   a_keep_coef: assert property (p_keep_coef) else $error("coef reg not held");
endmodule : qmsa_top_props
bind qmsa_top qmsa_top_props u_props (.clk_i(clk_i), .arst_n_i(arst_n_i),
   .lane_data_in_i(lane_data_in_i), .lane_coef_in_i(lane_coef_in_i),
   .lane_input_enable_n_i(lane_input_enable_n_i), .enable_target_select_i(enable_target_select_i),
   .output_reg_clock_enable_n_i(output_reg_clock_enable_n_i),
   .number_format_select_i(number_format_select_i), .accumulate_control_i(accumulate_control_i),
   .output_drive_enable_n_i(output_drive_enable_n_i), .result_bus_o(result_bus_o),
   .result_bus_oe_o(result_bus_oe_o), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i));

/* dv/test_quad_mult_sum_accumulator.sv */
`timescale 1ns/10ps
module test_quad_mult_sum_accumulator;
   import qmsa_pkg::*;
   logic clk = 0, arst_n = 0, ens = 0, output_reg_clock_enable_n_n = 0, number_format_select = 0, acc = 0, oen_n = 0;
   logic [39:0] ld = '0;
   logic [43:0] lc = '0;
   logic [3:0]  len_n = '0;
   logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, oe, hold_m = 0, float_m = 0, er;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [15:0] res, bus_lvl, eout;
   logic [39:0] md;
   logic [43:0] mc;
   logic signed [24:0] s1, s2, eacc;
   logic a0, f0, a1, f1, a2, f2, f3;
   int mismatches = 0, tests_run = 0;
   initial forever #2.5 clk = ~clk;
   qmsa_top i_dut (.clk_i(clk), .arst_n_i(arst_n), .lane_data_in_i(ld), .lane_coef_in_i(lc),
      .lane_input_enable_n_i(len_n), .enable_target_select_i(ens),
      .output_reg_clock_enable_n_i(output_reg_clock_enable_n_n), .number_format_select_i(number_format_select),
      .accumulate_control_i(acc), .output_drive_enable_n_i(oen_n), .result_bus_o(res),
      .result_bus_oe_o(oe), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr));
   qmsa_bus_sink i_sink (.clk_i(clk), .result_i(res), .oe_i(oe), .bus_level_o(bus_lvl));
   function automatic logic signed [24:0] psum(input logic [39:0] d, input logic [43:0] c);
      logic signed [24:0] s;
      s = '0;
      for (int n = 0; n < 4; n++) s += $signed(d[n*10+:10]) * $signed(c[n*11+:11]);
      return s;
   endfunction : psum
   //----------------------------------------------------------------------
   // reference pipeline, stages in reverse order
   //----------------------------------------------------------------------
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         {md, mc, s1, s2, eacc, a0, f0, a1, f1, a2, f2, f3, eout} = '0;
      end else begin
         if (!output_reg_clock_enable_n_n && !hold_m) eout = f3 ? eacc[15:0] : eacc[24:9];
         f3 = f2;
         eacc = a2 ? eacc + s2 : s2 + (f2 ? 25'h000_0000 : 25'h000_0100);
         {s2, a2, f2} = {s1, a1, f1};
         {s1, a1, f1} = {psum(md, mc), a0, f0};
         for (int n = 0; n < 4; n++) begin
            if (!len_n[n] || !ens) md[n*10+:10] = ld[n*10+:10];
            if (!len_n[n] || ens) mc[n*11+:11] = lc[n*11+:11];
         end
         {a0, f0} = {acc, number_format_select};
      end
   end
   task bad(input string m);
      mismatches++;
      $display("BAD %0t %s", $time, m);
   endtask : bad
   always @(negedge clk) if (arst_n) begin
      tests_run += 3;
      if (res !== eout) bad("result");
      if (oe !== (!oen_n && !float_m)) bad("drive enable");
      if (oe && bus_lvl !== eout) bad("bus level");
   end
   task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, wd};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      {rd, er} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
      if (w && a == QMSA_OFS_CTRL) {float_m, hold_m} <= wd[1:0];
   endtask : apb
   task drv(input logic [3:0] e, input logic es, input logic [39:0] d, input logic [43:0] c,
            input logic fs, input logic ac);
      @(posedge clk);
      {len_n, ens, ld, lc, number_format_select, acc, output_reg_clock_enable_n_n, oen_n} <= {e, es, d, c, fs, ac, 2'b00};
   endtask : drv
   task results;
      if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : results
   initial begin
      #200000;
      mismatches++;
      results();
   end
   initial begin
      void'($urandom(32'h73bc_f27e));
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      apb(1'b0, QMSA_OFS_CTRL, '0);
      tests_run++;
      if (rd !== QMSA_CTRL_RST) bad("ctrl reset");
      for (int i = 0; i < 3000; i++) begin
         @(posedge clk);
         {ld, lc} <= 84'({$urandom, $urandom, $urandom});
         {len_n, ens, number_format_select} <= 6'($urandom);
         {acc, output_reg_clock_enable_n_n, oen_n} <= {$urandom % 4 != 0, $urandom % 8 == 0, $urandom % 8 == 0};
         if ($urandom % 32 == 0) case ($urandom % 4)
            0: apb(1'b1, QMSA_OFS_CTRL, {30'h0, $urandom % 4 == 0, $urandom % 4 == 0});
            1: begin
               apb(1'b0, QMSA_OFS_CTRL, '0);
               tests_run++;
               if (rd !== {30'h0, float_m, hold_m}) bad("ctrl readback");
            end
            2: begin
               apb(1'b0, 12'h010, '0);
               tests_run++;
               if (er !== 1'b1 || rd !== QMSA_ZERO32) bad("unmapped");
            end
            default: apb(1'b1, QMSA_OFS_RESULT, 32'hffff_ffff);
         endcase
      end
      @(posedge clk);
      apb(1'b1, QMSA_OFS_CTRL, '0);
      repeat (40) drv(4'h0, 1'b0, {4{10'h200}}, {4{11'h400}}, 1'($urandom), 1'b1);
      drv(4'h0, 1'b0, 40'h00_0000_0001, 44'h000_0000_0001, 1'b1, 1'b0);
      drv(4'h0, 1'b0, 40'h00_0000_0001, 44'h000_0000_0001, 1'b1, 1'b1);
      drv(4'h0, 1'b0, 40'h00_0000_0001, 44'h000_0000_0001, 1'b1, 1'b0);
      drv(4'h1, 1'b1, 40'h0, 44'h000_0000_0001, 1'b1, 1'b0);
      drv(4'h0, 1'b0, 40'h00_0000_0001, 44'h000_0000_0001, 1'b1, 1'b0);
      drv(4'h1, 1'b0, 40'h00_0000_0001, 44'h0, 1'b1, 1'b0);
      drv(4'h0, 1'b0, 40'h00_0000_0001, 44'h000_0000_0100, 1'b0, 1'b0);
      repeat (6) drv(4'h0, 1'b0, 40'h0, 44'h0, 1'b1, 1'b0);
      // let the last samples leave the pipe
      repeat (8) @(posedge clk);
      results();
   end
endmodule : test_quad_mult_sum_accumulator

/* verilog/qmsa_lane.sv */
`timescale 1ns/10ps
module qmsa_lane #(
   parameter int unsigned DATA_W = qmsa_pkg::QMSA_DATA_W,
   parameter int unsigned COEF_W = qmsa_pkg::QMSA_COEF_W
) (
   input  wire logic                              clk_i,
   input  wire logic                              arst_n_i,
   input  wire logic        [DATA_W-1:0]          lane_data_in_i,
   input  wire logic        [COEF_W-1:0]          lane_coef_in_i,
   input  wire logic                              lane_input_enable_n_i,
   input  wire logic                              enable_target_select_i,
   output logic signed      [DATA_W+COEF_W-1:0]   product_o
);
   import qmsa_pkg::*;

   localparam int unsigned PROD_W = DATA_W + COEF_W;

   typedef struct packed {
      logic        [DATA_W-1:0] lane_data_reg;
      logic        [COEF_W-1:0] lane_coef_reg;
      logic signed [PROD_W-1:0] product;
   } qmsa_lane_state_t;

   qmsa_lane_state_t st;
   qmsa_lane_state_t next_st;

   //-------------------------------------------------------------------
   // input registers and multiplier stage
   //-------------------------------------------------------------------
   always_comb begin
      next_st = st;
      // enable low loads both; enable high picks one by the select
      if (!lane_input_enable_n_i || !enable_target_select_i) begin   // [RULE12] [RULE13]
         next_st.lane_data_reg = lane_data_in_i;                     // [RULE6] [RULE4]
      end
      if (!lane_input_enable_n_i || enable_target_select_i) begin    // [RULE12] [RULE14]
         next_st.lane_coef_reg = lane_coef_in_i;                     // [RULE7] [RULE4]
      end
      // format does not change the bit product, only its weight
      next_st.product = PROD_W'($signed(st.lane_data_reg) *
                                $signed(st.lane_coef_reg));          // [RULE1] [RULE5]
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;                                              // [RULE3]
      end
   end

   assign product_o = st.product;

endmodule : qmsa_lane

/* verilog/qmsa_pkg.sv */
//----------------------------------------------------------------------
// Summary of operation
// [RULE1] four signed 11x10 multipliers feed a summer and 25-bit accumulator
// [RULE2] five clock cycles from registered input to registered result
// [RULE3] inputs, controls and result registered on rising edge; drive enable not
// [RULE4] only enabled input registers load; disabled ones keep their contents
// [RULE5] new data and coefficient accepted every cycle, fractional or integer
// [RULE6] four 10-bit data ports, bit 0 least significant, per-lane register
// [RULE7] four 11-bit coefficient ports, bit 0 least significant, per-lane register
// [RULE8] 16-bit result taken from accumulator path, refreshed each cycle unless held
// [RULE9] output clock-enable lets the user freeze the output register
// [RULE10] 25-bit sum may grow and is optionally rounded to 16 bits
// [RULE11] format low is fractional, high is integer; sign weights -1 and -2
// [RULE12] lane enable low loads both data and coefficient registers
// [RULE13] lane enable high, select low: data loads, coefficient holds
// [RULE14] lane enable high, select high: data holds, coefficient loads
// [RULE15] output drive enable acts without the clock on the bus drive
// [RULE16] output clock-enable low loads result, high holds; accumulation continues (the code also holds while the CTRL hold bit is set)
// [RULE17] fractional outputs upper 16 bits rounded; integer outputs lower 16 unrounded
// [RULE18] accumulate low clears sum and rounds half LSB; high adds without rounding
// [RULE19] drive enable low drives output register onto bus, high floats it (the code also floats it while the CTRL float bit is set)
// [RULE20] products sign-extended to 25 bits; accumulator wraps without saturation
// [RULE21] format and accumulate controls travel aligned with their own products
//----------------------------------------------------------------------
package qmsa_pkg;

   //-------------------------------------------------------------------
   // datapath geometry
   //-------------------------------------------------------------------
   localparam int unsigned QMSA_LANES      = 4;
   localparam int unsigned QMSA_DATA_W     = 10;
   localparam int unsigned QMSA_COEF_W     = 11;
   localparam int unsigned QMSA_ACC_W      = 25;
   localparam int unsigned QMSA_OUT_W      = 16;
   localparam int unsigned QMSA_LATENCY    = 5;

   //-------------------------------------------------------------------
   // control pipeline stage indexes
   //-------------------------------------------------------------------
   localparam int unsigned QMSA_STG_IN     = 0;
   localparam int unsigned QMSA_STG_PROD   = 1;
   localparam int unsigned QMSA_STG_SUM    = 2;
   localparam int unsigned QMSA_STG_ACC    = 3;
   localparam int unsigned QMSA_STAGES     = 4;

   //-------------------------------------------------------------------
   // register map (byte addresses)
   //-------------------------------------------------------------------
   localparam int unsigned QMSA_ADDR_W     = 12;
   localparam logic [11:0] QMSA_OFS_CTRL   = 12'h000;
   localparam logic [11:0] QMSA_OFS_RESULT = 12'h004;
   localparam logic [11:0] QMSA_OFS_ACCUM  = 12'h008;
   localparam logic [11:0] QMSA_OFS_STATUS = 12'h00c;

   localparam int unsigned QMSA_CTRL_HOLD  = 0;
   localparam int unsigned QMSA_CTRL_FLOAT = 1;
   localparam int unsigned QMSA_ST_NUMBER_FORMAT_SELECT    = 0;
   localparam int unsigned QMSA_ST_ACC     = 1;
   localparam int unsigned QMSA_ST_DRIVE   = 2;

   localparam logic [31:0] QMSA_CTRL_RST   = 32'h0000_0000;
   localparam logic [31:0] QMSA_ZERO32     = 32'h0000_0000;

endpackage : qmsa_pkg

/* verilog/qmsa_top.sv */
// The address map and the APB register port were decided locally.
`timescale 1ns/10ps
module qmsa_top #(
   parameter int unsigned LANES  = qmsa_pkg::QMSA_LANES,
   parameter int unsigned DATA_W = qmsa_pkg::QMSA_DATA_W,
   parameter int unsigned COEF_W = qmsa_pkg::QMSA_COEF_W,
   parameter int unsigned ACC_W  = qmsa_pkg::QMSA_ACC_W,
   parameter int unsigned OUT_W  = qmsa_pkg::QMSA_OUT_W
) (
   input  wire logic                                clk_i,
   input  wire logic                                arst_n_i,
   // stream side
   input  wire logic [LANES*DATA_W-1:0]             lane_data_in_i,
   input  wire logic [LANES*COEF_W-1:0]             lane_coef_in_i,
   input  wire logic [LANES-1:0]                    lane_input_enable_n_i,
   input  wire logic                                enable_target_select_i,
   input  wire logic                                output_reg_clock_enable_n_i,
   input  wire logic                                number_format_select_i,
   input  wire logic                                accumulate_control_i,
   input  wire logic                                output_drive_enable_n_i,
   output logic      [OUT_W-1:0]                    result_bus_o,
   output logic                                     result_bus_oe_o,
   // apb slave
   input  wire logic                                psel_i,
   input  wire logic                                penable_i,
   input  wire logic                                pwrite_i,
   input  wire logic [qmsa_pkg::QMSA_ADDR_W-1:0]    paddr_i,
   input  wire logic [31:0]                         pwdata_i,
   output logic      [31:0]                         prdata_o,
   output logic                                     pready_o,
   output logic                                     pslverr_o
);
   import qmsa_pkg::*;

   localparam int unsigned PROD_W = DATA_W + COEF_W;
   localparam int unsigned SHIFT  = ACC_W - OUT_W;

   //-------------------------------------------------------------------
   // elaboration checks
   //-------------------------------------------------------------------
   generate
      if (LANES < 1 || ACC_W < PROD_W + 2 || OUT_W > ACC_W || SHIFT < 1 ||
          ACC_W > 32 || OUT_W > 32) begin : g_bad_params
         $error("qmsa_top: unsupported width or lane parameters");
      end
   endgenerate

   //-------------------------------------------------------------------
   // helper functions
   //-------------------------------------------------------------------
   function automatic logic is_frac(input logic fmt);
      is_frac = !fmt;                                                // [RULE11]
   endfunction : is_frac

   function automatic logic [31:0] sext_acc(input logic signed [ACC_W-1:0] v);
      sext_acc = 32'($signed(v));
   endfunction : sext_acc

   //-------------------------------------------------------------------
   // state
   //-------------------------------------------------------------------
   typedef struct packed {
      logic [QMSA_STAGES-1:0]  fmt_pipe;
      logic [QMSA_STAGES-1:0]  acc_pipe;
      logic signed [ACC_W-1:0] sum;
      logic signed [ACC_W-1:0] accum;
      logic [OUT_W-1:0]        result;
      logic                    hold_out;
      logic                    float_out;
      logic [31:0]             rdata;
      logic                    slverr;
   } qmsa_state_t;

   qmsa_state_t st;
   qmsa_state_t next_st;

   logic signed [PROD_W-1:0] prod [LANES];

   //-------------------------------------------------------------------
   // lanes: input registers and multipliers
   //-------------------------------------------------------------------
   generate
      for (genvar g = 0; g < LANES; g++) begin : g_lane
         qmsa_lane #(
            .DATA_W (DATA_W),
            .COEF_W (COEF_W)
         ) u_lane (
            .clk_i                  (clk_i),
            .arst_n_i               (arst_n_i),
            .lane_data_in_i         (lane_data_in_i[g*DATA_W +: DATA_W]),
            .lane_coef_in_i         (lane_coef_in_i[g*COEF_W +: COEF_W]),
            .lane_input_enable_n_i  (lane_input_enable_n_i[g]),
            .enable_target_select_i (enable_target_select_i),
            .product_o              (prod[g])
         );
      end
   endgenerate

   //-------------------------------------------------------------------
   // summer, accumulator, output selection
   //-------------------------------------------------------------------
   logic signed [ACC_W-1:0] prod_total;
   logic signed [ACC_W-1:0] round_add;
   logic [OUT_W-1:0]        out_sel;
   logic                    apb_setup;
   logic                    apb_access;

   always_comb begin
      prod_total = '0;
      for (int i = 0; i < LANES; i++) begin
         prod_total = prod_total + ACC_W'(prod[i]);                  // [RULE20] [RULE1]
      end
   end

   // half output LSB, only when a fresh fractional sum starts
   always_comb begin
      round_add = '0;
      if (is_frac(st.fmt_pipe[QMSA_STG_SUM]) && !st.acc_pipe[QMSA_STG_SUM]) begin
         round_add[SHIFT-1] = 1'b1;                                  // [RULE18] [RULE10]
      end
   end

   always_comb begin
      if (is_frac(st.fmt_pipe[QMSA_STG_ACC])) begin
         out_sel = st.accum[ACC_W-1 -: OUT_W];                       // [RULE17]
      end else begin
         out_sel = st.accum[OUT_W-1:0];                              // [RULE17]
      end
   end

   assign apb_setup  = psel_i && !penable_i;
   assign apb_access = psel_i && penable_i;

   always_comb begin
      next_st = st;

      // control flags follow their own samples down the pipe
      next_st.fmt_pipe = {st.fmt_pipe[QMSA_STAGES-2:0], number_format_select_i}; // [RULE21]
      next_st.acc_pipe = {st.acc_pipe[QMSA_STAGES-2:0], accumulate_control_i};   // [RULE21]

      // stage 3: sum of the four products
      next_st.sum = prod_total;                                      // [RULE1]

      // stage 4: accumulate or restart, wraps silently
      if (st.acc_pipe[QMSA_STG_SUM]) begin
         next_st.accum = st.accum + st.sum;                          // [RULE18] [RULE20]
      end else begin
         next_st.accum = st.sum + round_add;                         // [RULE18]
      end

      // stage 5: output register with user hold
      if (!output_reg_clock_enable_n_i && !st.hold_out) begin        // [RULE9] [RULE16]
         next_st.result = out_sel;                                   // [RULE8] [RULE2]
      end

      // apb: read data captured in setup, answered in access
      if (apb_setup) begin
         next_st.slverr = 1'b0;
         next_st.rdata  = QMSA_ZERO32;
         case (paddr_i)
            QMSA_OFS_CTRL: begin
               next_st.rdata[QMSA_CTRL_HOLD]  = st.hold_out;
               next_st.rdata[QMSA_CTRL_FLOAT] = st.float_out;
            end
            QMSA_OFS_RESULT: begin
               next_st.rdata[OUT_W-1:0] = st.result;
            end
            QMSA_OFS_ACCUM: begin
               next_st.rdata = sext_acc(st.accum);
            end
            QMSA_OFS_STATUS: begin
               next_st.rdata[QMSA_ST_NUMBER_FORMAT_SELECT]  = st.fmt_pipe[QMSA_STG_ACC];
               next_st.rdata[QMSA_ST_ACC]   = st.acc_pipe[QMSA_STG_ACC];
               next_st.rdata[QMSA_ST_DRIVE] = result_bus_oe_o;
            end
            default: begin
               next_st.slverr = 1'b1;
            end
         endcase
      end
      if (apb_access && pwrite_i && paddr_i == QMSA_OFS_CTRL) begin
         next_st.hold_out  = pwdata_i[QMSA_CTRL_HOLD];
         next_st.float_out = pwdata_i[QMSA_CTRL_FLOAT];
      end
   end

   //-------------------------------------------------------------------
   // registers
   //-------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;                                              // [RULE3]
      end
   end

   //-------------------------------------------------------------------
   // outputs
   //-------------------------------------------------------------------
   assign result_bus_o    = st.result;                               // [RULE19]
   // unclocked drive control
   assign result_bus_oe_o = !output_drive_enable_n_i && !st.float_out; // [RULE15] [RULE19]
   assign prdata_o        = st.rdata;
   assign pready_o        = 1'b1;
   assign pslverr_o       = apb_access && st.slverr;

endmodule : qmsa_top
